// ===== rtl/status_led_encoder.sv
// Purpose: map status conditions onto front-panel indicators
// Assumes: axi4-lite slave, 125 MHz aclk, synchronous active-low reset
// Notes: link and channel inputs are pins and pass two flip-flops
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module status_led_encoder
  import led_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // status pins
  input wire logic [1:0] link_up,
  input wire logic [nchan-1:0] chan_signal,
  // indicators
  output panel_t panel,
  output logic supply_indicator,
  output logic [nchan-1:0] binary_channel_indicator,
  output logic [nport-1:0] fieldbus_port_indicator,
  output logic irq
);
  logic flash_2hz;
  logic flash_1hz;
  flash_gen u_flash (
    .aclk(aclk),
    .aresetn(aresetn),
    .flash_2hz(flash_2hz),
    .flash_1hz(flash_1hz),
    .flash_half_hz()
  );

  // pin synchronisers
  logic [1:0] link_s1_reg;
  logic [1:0] link_reg;
  logic [nchan-1:0] chan_s1_reg;
  logic [nchan-1:0] chan_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_s1_reg <= 2'h0;
      link_reg <= 2'h0;
      chan_s1_reg <= '0;
      chan_reg <= '0;
    end else begin
      link_s1_reg <= link_up;
      link_reg <= link_s1_reg;
      chan_s1_reg <= chan_signal;
      chan_reg <= chan_s1_reg;
    end
  end

  // software registers
  logic [31:0] ctrl_reg;
  logic [31:0] chan_fault_reg; // 4 bits per channel
  logic [31:0] port_reg; // [7:0] present, [15:8] startup, [23:16] alarm
  logic [4:0] stat_reg;
  logic [4:0] mask_reg;
  logic [4:0] events;

  // axi write path
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  assign s_awready = !aw_held_reg && !s_bvalid;
  assign s_wready = !w_held_reg && !s_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok(awaddr_reg) ? 2'h0 : 2'h2;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_ok(input logic [7:0] a);
    wr_ok = (a == addr_ctrl) || (a == addr_chan) || (a == addr_port) ||
            (a == addr_cond) || (a == addr_stat) || (a == addr_mask);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  logic wr_ctrl;
  logic wr_chan;
  logic wr_port;
  logic wr_cond;
  logic wr_stat;
  logic wr_mask;
  assign wr_ctrl = wr_fire && awaddr_reg == addr_ctrl;
  assign wr_chan = wr_fire && awaddr_reg == addr_chan;
  assign wr_port = wr_fire && awaddr_reg == addr_port;
  assign wr_cond = wr_fire && awaddr_reg == addr_cond;
  assign wr_stat = wr_fire && awaddr_reg == addr_stat;
  assign wr_mask = wr_fire && awaddr_reg == addr_mask;

  // addr_chan holds force-on bits for the channel signals, ORed with the pins
  logic [31:0] chan_force_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ctrl_reset;
      chan_force_reg <= 32'h0;
      port_reg <= 32'h0;
      chan_fault_reg <= 32'h0;
      mask_reg <= mask_reset;
    end else begin
      if (wr_ctrl) ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
      if (wr_chan) chan_force_reg <= merge(chan_force_reg, wdata_reg, wstrb_reg);
      if (wr_port) port_reg <= merge(port_reg, wdata_reg, wstrb_reg);
      if (wr_cond) chan_fault_reg <= merge(chan_fault_reg, wdata_reg, wstrb_reg);
      if (wr_mask && wstrb_reg[0]) mask_reg <= wdata_reg[4:0];
    end
  end

  // channel view: pin signal, or forced on via the low byte
  logic [nchan-1:0] chan_on;
  assign chan_on = chan_reg | chan_force_reg[nchan-1:0];

  // per-channel and per-port decoding
  logic [nchan-1:0] chan_faulty;
  logic [nport-1:0] port_startup;
  logic [nport-1:0] port_alarm;
  logic [nchan-1:0] chan_led_d;
  logic [nport-1:0] port_led_d;
  genvar g;
  generate
    for (g = 0; g < nchan; g++) begin : g_chan
      chan_fault_t cf;
      assign cf = chan_fault_reg[g*4 +: 4];
      assign chan_faulty[g] = |cf;
      assign chan_led_d[g] = chan_on[g];
      assign port_startup[g] = port_reg[8 + g] && !port_reg[16 + g];
      assign port_alarm[g] = port_reg[16 + g];
      // alarm holds lit, startup flashes, else presence
      assign port_led_d[g] = port_alarm[g] ? 1'b1 :
                             port_startup[g] ? flash_1hz : port_reg[g];
    end
  endgenerate

  logic group_fault;
  logic maint_req;
  assign group_fault = ctrl_reg[ctrl_group] | ctrl_reg[ctrl_struct] | ctrl_reg[ctrl_param];
  assign maint_req = ctrl_reg[ctrl_warn] | ctrl_reg[ctrl_service];

  // fault/maintenance priority: interrupt classes, then maintenance, else off
  logic fm_d;
  always_comb begin
    if (|chan_faulty || |port_alarm) begin
      fm_d = flash_2hz;
    end else if (maint_req) begin
      fm_d = flash_2hz;
    end else begin
      fm_d = 1'b0;
    end
  end

  // registered indicator outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel <= '0;
      supply_indicator <= 1'b0;
      binary_channel_indicator <= '0;
      fieldbus_port_indicator <= '0;
    end else if (!ctrl_reg[ctrl_enable]) begin
      panel <= '0;
      supply_indicator <= 1'b0;
      binary_channel_indicator <= '0;
      fieldbus_port_indicator <= '0;
    end else begin
      panel.link1 <= link_reg[0];
      panel.link2 <= link_reg[1];
      panel.fault_maint <= fm_d;
      // shared group-fault pattern on supply and run
      panel.run <= group_fault ? flash_2hz : 1'b1;
      supply_indicator <= group_fault ? flash_2hz : 1'b1;
      binary_channel_indicator <= chan_led_d;
      fieldbus_port_indicator <= port_led_d;
    end
  end

  // sticky events, set wins over write-one-clear
  logic [1:0] link_prev_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) link_prev_reg <= 2'h0;
    else link_prev_reg <= link_reg;
  end
  assign events = {maint_req, |port_alarm, |chan_faulty, link_reg ^ link_prev_reg};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 5'h0;
    end else begin
      stat_reg <= (stat_reg & ~((wr_stat && wstrb_reg[0]) ? wdata_reg[4:0] : 5'h0)) | events;
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // axi read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= 2'h0;
      case (s_araddr)
        addr_ctrl: s_rdata <= ctrl_reg;
        addr_chan: s_rdata <= chan_force_reg;
        addr_port: s_rdata <= port_reg;
        addr_cond: s_rdata <= chan_fault_reg;
        addr_stat: s_rdata <= {27'h0, stat_reg};
        addr_mask: s_rdata <= {27'h0, mask_reg};
        addr_leds: s_rdata <= {8'h0, fieldbus_port_indicator, binary_channel_indicator, 3'h0,
                               supply_indicator, panel};
        default: begin
          s_rdata <= 32'h0;
          s_rresp <= 2'h2;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
  assign s_arready = !s_rvalid;

  // checks; the release edge escapes disable iff, so sample aresetn there
  property p_link;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_reg[ctrl_enable] |=> panel.link1 == $past(link_reg[0]) && panel.link2 == $past(link_reg[1]);
  endproperty
  a_link: assert property (p_link) else $error("link indicator does not follow link");
  property p_group;
    @(posedge aclk) disable iff (!aresetn)
      (aresetn && ctrl_reg[ctrl_enable] && !group_fault) |=> panel.run && supply_indicator;
  endproperty
  a_group: assert property (p_group) else $error("run not steady on without group fault");
  property p_grp_flash;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_reg[ctrl_enable] && group_fault) |=> panel.run == $past(flash_2hz);
  endproperty
  a_grp_flash: assert property (p_grp_flash) else $error("run not flashing on group fault");
  property p_grp_same;
    @(posedge aclk) disable iff (!aresetn) panel.run == supply_indicator;
  endproperty
  a_grp_same: assert property (p_grp_same) else $error("supply and run patterns differ");
  property p_healthy;
    @(posedge aclk) disable iff (!aresetn)
      (!(|chan_faulty) && !(|port_alarm) && !maint_req) |=> !panel.fault_maint;
  endproperty
  a_healthy: assert property (p_healthy) else $error("fault indicator lit while healthy");
  property p_maint;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_reg[ctrl_enable] && maint_req) |=> panel.fault_maint == $past(flash_2hz);
  endproperty
  a_maint: assert property (p_maint) else $error("maintenance not flashing");
  property p_chan;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_reg[ctrl_enable] |=> binary_channel_indicator == $past(chan_on);
  endproperty
  a_chan: assert property (p_chan) else $error("channel indicator not following signal");
  property p_fault;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_reg[ctrl_enable] && |chan_faulty) |=> panel.fault_maint == $past(flash_2hz);
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flashing");
  property p_alarm;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_reg[ctrl_enable] && |port_alarm) |=> (fieldbus_port_indicator & $past(port_alarm)) == $past(port_alarm);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm port indicator not lit");
  sequence s_startup;
    ctrl_reg[ctrl_enable] && port_startup[0];
  endsequence
  property p_startup;
    @(posedge aclk) disable iff (!aresetn) s_startup |=> fieldbus_port_indicator[0] == $past(flash_1hz);
  endproperty
  a_startup: assert property (p_startup) else $error("startup port not flashing");
  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (|events) |=> (stat_reg & $past(events)) == $past(events);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status event lost");
  property p_off;
    @(posedge aclk) disable iff (!aresetn)
      !ctrl_reg[ctrl_enable] |=> (panel == '0) && !supply_indicator &&
        binary_channel_indicator == '0 && fieldbus_port_indicator == '0;
  endproperty
  a_off: assert property (p_off) else $error("indicators lit while disabled");
  sequence s_rst;
    !aresetn;
  endsequence
  property p_reset;
    @(posedge aclk) s_rst |=> (panel == '0) && !supply_indicator &&
      binary_channel_indicator == '0 && fieldbus_port_indicator == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("indicators not dark after reset");
endmodule

// ===== rtl/led_pkg.sv
// Purpose: constants and types for the status indicator encoder
// Assumes: 125 MHz system clock, axi4-lite register access
// Notes: flash rates derived from one prescaler
// Behaviour
// - Each port link indicator is lit while its Ethernet link is up and dark otherwise.
// - Group fault, structure mismatch and parameter error share one group-fault pattern on supply and run indicators.
// - Warning limits exceeded or service port enabled flash the fault/maintenance indicator at about 2 Hz.
// - A healthy binary channel keeps fault/maintenance off and its channel indicator follows the signal.
// - Temperature rise, missing load voltage, external supply or communication error flash fault/maintenance as interrupt.
// - During field device startup the fieldbus port indicator flashes and fault/maintenance stays off.
// - Pending cyclic-service alarms show as an interrupt-class state on the affected fieldbus port indicator (the code holds it steadily lit).
package led_pkg;
  localparam int clk_hz = 125_000_000;
  localparam int tick_hz = 8;
  localparam int tick_cycles = clk_hz / tick_hz;
  localparam int nchan = 8;
  localparam int nport = 8;
  // register byte addresses
  localparam logic [7:0] addr_ctrl = 8'h00;
  localparam logic [7:0] addr_chan = 8'h04;
  localparam logic [7:0] addr_port = 8'h08;
  localparam logic [7:0] addr_cond = 8'h0c;
  localparam logic [7:0] addr_stat = 8'h10;
  localparam logic [7:0] addr_mask = 8'h14;
  localparam logic [7:0] addr_leds = 8'h18;
  // ctrl bits
  localparam int ctrl_enable = 0;
  localparam int ctrl_group = 1;
  localparam int ctrl_struct = 2;
  localparam int ctrl_param = 3;
  localparam int ctrl_warn = 4;
  localparam int ctrl_service = 5;
  localparam logic [31:0] ctrl_reset = 32'h0000_0001;
  // status bits
  localparam int st_link1 = 0;
  localparam int st_link2 = 1;
  localparam int st_chan_fault = 2;
  localparam int st_port_alarm = 3;
  localparam int st_maint = 4;
  localparam logic [4:0] mask_reset = 5'h00;
  typedef struct packed {
    logic temp_rise;
    logic no_load_volt;
    logic ext_supply;
    logic comm_err;
  } chan_fault_t;
  typedef struct packed {
    logic run;
    logic fault_maint;
    logic link1;
    logic link2;
  } panel_t;
endpackage

// ===== rtl/flash_gen.sv
// Purpose: free-running flash pattern generator
// Assumes: single clock, synchronous active-low reset
// Notes: outputs 2 Hz, 1 Hz and 0.5 Hz square waves
`timescale 1ns/1ps
module flash_gen
  import led_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // patterns
  output logic flash_2hz,
  output logic flash_1hz,
  output logic flash_half_hz
);
  logic [31:0] pre_reg;
  logic [3:0] div_reg;
  logic tick;
  assign tick = (pre_reg == 32'(tick_cycles - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= 32'h0;
      div_reg <= 4'h0;
    end else begin
      pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
      if (tick) begin
        div_reg <= div_reg + 4'h1;
      end
    end
  end
  assign flash_2hz = div_reg[1];
  assign flash_1hz = div_reg[2];
  assign flash_half_hz = div_reg[3];
endmodule

// ===== testbench/led_viewer.sv
// Purpose: operator model that looks at the front panel
// Assumes: one sample per aclk edge
// Notes: view lags the indicators by one clock
`timescale 1ns/1ps
module led_viewer
  import led_pkg::*;
(
  // clock
  input wire logic aclk,
  // indicators
  input panel_t panel,
  input wire logic supply_indicator,
  input wire logic [nchan-1:0] binary_channel_indicator,
  input wire logic [nport-1:0] fieldbus_port_indicator,
  // what the operator sees
  output logic [20:0] view
);
  // the operator only sees lit or dark, never a handshake
  always_ff @(posedge aclk) begin
    view <= {panel, supply_indicator, binary_channel_indicator, fieldbus_port_indicator};
  end
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench for the status indicator encoder
// Assumes: flash phases stay dark, run is far shorter than one tick
// Notes: flashing outputs are checked in their first, dark half period
`timescale 1ns/1ps
module tb
  import led_pkg::*;
;
  logic aclk, aresetn;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, link_up;
  logic [nchan-1:0] chan_signal, binary_channel_indicator;
  logic [nport-1:0] fieldbus_port_indicator;
  panel_t panel;
  logic supply_indicator, irq;
  logic [20:0] view;
  int mismatches, check_count, k;

  status_led_encoder DUT (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .link_up, .chan_signal, .panel, .supply_indicator,
    .binary_channel_indicator, .fieldbus_port_indicator, .irq);
  led_viewer eye (.aclk, .panel, .supply_indicator, .binary_channel_indicator,
    .fieldbus_port_indicator, .view);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    mismatches++;
    close_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    if (i == 64) give_up();
    chk({30'h0, s_bresp}, {30'h0, er});
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    if (i == 64) give_up();
    chk({30'h0, s_rresp}, {30'h0, er});
    // data is meaningless on an error answer
    if (er == 2'h0) chk(s_rdata, ed);
    s_rready <= 1'b0;
  endtask

  // pins need two sync flops plus the output register, the viewer one more
  task automatic cv(input logic [20:0] e);
    repeat (5) @(posedge aclk);
    chk({11'h0, view}, {11'h0, e});
  endtask

  initial begin
    aresetn = 1'b0;
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hf;
    link_up = 2'b00;
    chan_signal = 8'h00;
    repeat (12) @(posedge aclk);
    chk({10'h0, view, irq}, 32'h0);
    aresetn <= 1'b1;
    cv({4'b1000, 1'b1, 16'h0});
    link_up <= 2'b01;
    cv({4'b1010, 1'b1, 16'h0});
    link_up <= 2'b10;
    cv({4'b1001, 1'b1, 16'h0});
    link_up <= 2'b00;
    chan_signal <= 8'ha5;
    cv({4'b1000, 1'b1, 8'ha5, 8'h00});
    wr(addr_chan, 32'h5a, 2'h0);
    cv({4'b1000, 1'b1, 8'hff, 8'h00});
    wr(addr_chan, 32'h0, 2'h0);
    chan_signal <= 8'h00;
    rd(addr_ctrl, 32'h1, 2'h0);
    rd(addr_mask, 32'h0, 2'h0);
    for (k = 1; k < 4; k++) begin
      wr(addr_ctrl, 32'h1 | (32'h1 << k), 2'h0);
      cv({4'b0000, 1'b0, 16'h0});
    end
    wr(addr_ctrl, 32'h1, 2'h0);
    cv({4'b1000, 1'b1, 16'h0});
    rd(addr_stat, 32'h3, 2'h0);
    wr(addr_stat, 32'h1f, 2'h0);
    wr(addr_mask, 32'h1c, 2'h0);
    for (k = 4; k < 6; k++) begin
      wr(addr_ctrl, 32'h1 | (32'h1 << k), 2'h0);
      rd(addr_stat, 32'h10, 2'h0);
      chk({31'h0, irq}, 32'h1);
      wr(addr_ctrl, 32'h1, 2'h0);
      wr(addr_stat, 32'h10, 2'h0);
      rd(addr_stat, 32'h0, 2'h0);
      chk({31'h0, irq}, 32'h0);
    end
    for (k = 0; k < 4; k++) begin
      wr(addr_cond, 32'h1 << (28 + k), 2'h0);
      rd(addr_stat, 32'h4, 2'h0);
      chk({31'h0, irq}, 32'h1);
      wr(addr_cond, 32'h0, 2'h0);
      wr(addr_stat, 32'h4, 2'h0);
    end
    wr(addr_port, 32'h1, 2'h0);
    cv({4'b1000, 1'b1, 8'h00, 8'h01});
    wr(addr_port, 32'h101, 2'h0);
    cv({4'b1000, 1'b1, 8'h00, 8'h00});
    wr(addr_port, 32'h0080_0080, 2'h0);
    cv({4'b1000, 1'b1, 8'h00, 8'h80});
    rd(addr_stat, 32'h8, 2'h0);
    chk({31'h0, irq}, 32'h1);
    // enable cleared blanks every indicator
    wr(addr_ctrl, 32'h0, 2'h0);
    cv(21'h0);
    rd(8'h1c, 32'h0, 2'h2);
    wr(addr_leds, 32'h0, 2'h2);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    chk({10'h0, view, irq}, 32'h0);
    aresetn <= 1'b1;
    rd(addr_ctrl, 32'h1, 2'h0);
    rd(addr_port, 32'h0, 2'h0);
    close_out();
  end
endmodule
